// ==== rtl/spmh_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SPMH_REGS_SVH
`define SPMH_REGS_SVH

// Register indices on the host register port
`define SPMH_MCR_OFS     8'h05
`define SPMH_LSR_OFS     8'h0A

// Modem line force register fields
`define SPMH_MCR_DTR     0
`define SPMH_MCR_RTS     1
`define SPMH_MCR_DRS     2
`define SPMH_MCR_RST     8'h00

// Line status register fields
`define SPMH_LSR_RDY     0
`define SPMH_LSR_OVR     1
`define SPMH_LSR_PAR     2
`define SPMH_LSR_FRM     3
`define SPMH_LSR_BRK     4

// Clock rate, oversampling and line rates in baud
`define SPMH_CLK_HZ      125000000
`define SPMH_OVS         16
`define SPMH_BAUD_300    300
`define SPMH_BAUD_1200   1200
`define SPMH_BAUD_2400   2400
`define SPMH_BAUD_4800   4800
`define SPMH_BAUD_9600   9600
`define SPMH_BAUD_19200  19200

// Frame layout: start, data bits, optional parity, one stop
`define SPMH_DATA_BITS   8
`define SPMH_BASE_FRAME  10

`endif

// ==== rtl/spmh_pkg.sv ====
// Types shared by the serial port with modem handshake
package spmh_pkg;

	// Host operation in progress, one-hot
	typedef enum logic [2:0] {
		SPMH_OP_IDLE = 3'h1,
		SPMH_OP_TX   = 3'h2,
		SPMH_OP_RX   = 3'h4
	} spmh_op_e;

	// Receiver frame position, one-hot
	typedef enum logic [3:0] {
		SPMH_RX_IDLE  = 4'h1,
		SPMH_RX_START = 4'h2,
		SPMH_RX_DATA  = 4'h4,
		SPMH_RX_STOP  = 4'h8
	} spmh_rx_e;

	// Modem control outputs toward the peripheral
	typedef struct packed {
		logic dtr;
		logic rts;
		logic drs;
	} spmh_modem_s;

	// Sticky line status, packed as bits 4..0 of the status register
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
		logic ovr;
		logic rdy;
	} spmh_lsr_s;

endpackage : spmh_pkg

// ==== rtl/spmh_top.sv ====
// Serial port with automatic modem line handshake and receive error flags
//
// Notes on behaviour
// - Transmit start drives DTR and RTS active unless already forced active.
// - Characters go out only while DSR and CTS are both active.
// - Transmit end drops DTR and RTS, except lines the force register holds.
// - Receive start asserts DTR and leaves RTS at its force bit, inactive unless forced.
// - Characters are accepted only while DSR and DCD are both active.
// - Receive end drops DTR unless the force register holds it active.
// - Force register bit 2 drives the data rate select line directly.
// - Force bit 1 holds RTS, bit 0 holds DTR; cleared bits toggle per operation.
// - Transmit completion is reported only after the last stop bit leaves.
// - One received character is held; a second before it is taken overruns.
// - Parity mismatch against the expected parity sets a parity error.
// - Misplaced start or stop bit sets a framing error.
// - A character lost to an occupied hold buffer sets an overrun error.
// - A break on the receive line sets the break flag.
// - Only received data sets line errors; transmit never does.
// - Each receive error sets its status bit and raises the pending error.
// - Reading the line status register clears the pending error.
// - Frames carry eight data bits, a parity bit only when PAR_EN is set, one stop bit.
// - Line rate is one of 300 to 19200 baud; both ends must match.
`timescale 1ns/100ps
`include "spmh_regs.svh"

module spmh_top
	import spmh_pkg::*;
#(
	parameter int       CLK_HZ  = `SPMH_CLK_HZ,
	parameter bit       PAR_EN  = 1'b0,
	parameter bit       PAR_ODD = 1'b0
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	input  wire logic [2:0] baud_sel,
	input  wire logic       tx_begin,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready,
	input  wire logic       rx_begin,
	input  wire logic       rx_end,
	input  wire logic       rx_take,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            op_done,
	output logic            err_pending,
	output logic            txd,
	input  wire logic       rxd,
	output logic            dtr,
	output logic            rts,
	output logic            drs,
	input  wire logic       dsr,
	input  wire logic       cts,
	input  wire logic       dcd
);

	////////////////////////////////////////////////////////////////////////
	// Frame geometry and rate divisors
	localparam int       FRAME  = `SPMH_BASE_FRAME + int'(PAR_EN);
	localparam int       RBITS  = `SPMH_DATA_BITS + int'(PAR_EN);
	localparam logic [3:0] TLAST = 4'(FRAME - 1);
	localparam logic [3:0] RLAST = 4'(RBITS - 1);
	// Break needs the line low for more than a whole frame of ticks
	localparam logic [7:0] BRK   = 8'(FRAME * `SPMH_OVS);

	// Oversample divisor for the chosen rate; unknown codes fall to 300
	function automatic logic [15:0] rate_div(input logic [2:0] sel);
		int b;
		case (sel)
			3'h1: b = `SPMH_BAUD_1200;
			3'h2: b = `SPMH_BAUD_2400;
			3'h3: b = `SPMH_BAUD_4800;
			3'h4: b = `SPMH_BAUD_9600;
			3'h5: b = `SPMH_BAUD_19200;
			default: b = `SPMH_BAUD_300;
		endcase
		return 16'(CLK_HZ / (`SPMH_OVS * b));
	endfunction : rate_div

	////////////////////////////////////////////////////////////////////////
	// Whole block state
	typedef struct packed {
		spmh_op_e    op;
		spmh_rx_e    rxs;
		logic [7:0]  mcr;
		logic [15:0] pre;
		logic [10:0] tx_sh;
		logic [3:0]  tx_bits;
		logic [3:0]  tx_sub;
		logic        tx_busy;
		logic        tx_fin;
		logic        tx_ready;
		logic        txd;
		logic [8:0]  rx_sh;
		logic [3:0]  rx_bits;
		logic [3:0]  rx_sub;
		logic        rx_prev;
		logic [7:0]  low_cnt;
		logic [7:0]  hold;
		spmh_lsr_s   lsr;
		logic        pend;
		spmh_modem_s modem;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        done;
	} spmh_state_s;

	spmh_state_s s;
	spmh_state_s next_s;
	logic        tick;
	logic        ev_err;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [7:0] rx_byte;
		logic       rx_par;
		next_s = s;
		tick = 1'b0;
		ev_err = 1'b0;
		rx_byte = PAR_EN ? s.rx_sh[7:0] : s.rx_sh[8:1];
		rx_par = s.rx_sh[8];
		next_s.done = 1'b0;
		next_s.rvalid = 1'b0;
		// Oversample enable; reloads so a rate change takes effect quickly
		if (s.pre == 16'h0000) begin
			tick = 1'b1;
			next_s.pre = rate_div(baud_sel) - 16'h0001;
		end else begin
			next_s.pre = s.pre - 16'h0001;
		end
		// Register port: force register write, reads answer next cycle
		if (reg_wr && reg_addr == `SPMH_MCR_OFS) begin
			next_s.mcr = reg_wdata;
		end
		if (reg_rd) begin
			next_s.rvalid = 1'b1;
			case (reg_addr)
				`SPMH_MCR_OFS: next_s.rdata = s.mcr;
				`SPMH_LSR_OFS: next_s.rdata = {3'h0, s.lsr};
				default:       next_s.rdata = 8'h00;
			endcase
			// Clears come first so an error in this cycle survives
			if (reg_addr == `SPMH_LSR_OFS) begin
				next_s.pend = 1'b0;
				next_s.lsr.ovr = 1'b0;
				next_s.lsr.par = 1'b0;
				next_s.lsr.frm = 1'b0;
				next_s.lsr.brk = 1'b0;
			end
		end
		// Host operation sequencing
		case (s.op)
			SPMH_OP_IDLE: begin
				if (tx_begin) begin
					next_s.op = SPMH_OP_TX;
					next_s.tx_fin = 1'b0;
				end else if (rx_begin) begin
					next_s.op = SPMH_OP_RX;
				end
			end
			SPMH_OP_TX: begin
				if (s.tx_fin && !s.tx_busy) begin
					next_s.op = SPMH_OP_IDLE;
					next_s.done = 1'b1;
				end
			end
			SPMH_OP_RX: begin
				if (rx_end) begin
					next_s.op = SPMH_OP_IDLE;
					next_s.done = 1'b1;
				end
			end
			default: next_s.op = SPMH_OP_IDLE;
		endcase
		// Transmitter: load only what was offered under DSR and CTS
		if (tx_valid && s.tx_ready) begin
			next_s.tx_sh = PAR_EN ?
				{1'b1, ^tx_data ^ PAR_ODD, tx_data, 1'b0} :
				{2'b11, tx_data, 1'b0};
			next_s.tx_busy = 1'b1;
			next_s.tx_bits = 4'h0;
			next_s.tx_sub = 4'h0;
			next_s.tx_fin = tx_last;
		end else if (s.tx_busy && tick) begin
			next_s.tx_sub = s.tx_sub + 4'h1;
			if (s.tx_sub == 4'hF) begin
				next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
				next_s.tx_bits = s.tx_bits + 4'h1;
				// Busy ends only after the stop bit's full time
				if (s.tx_bits == TLAST) begin
					next_s.tx_busy = 1'b0;
				end
			end
		end
		next_s.txd = next_s.tx_busy ? next_s.tx_sh[0] : 1'b1;
		next_s.tx_ready = next_s.op == SPMH_OP_TX && !next_s.tx_busy &&
			!next_s.tx_fin && dsr && cts;
		// Host takes the held character before any new delivery
		if (rx_take) begin
			next_s.lsr.rdy = 1'b0;
		end
		// Break: a space held longer than one frame flags once
		if (tick) begin
			if (rxd) begin
				next_s.low_cnt = 8'h00;
			end else if (s.low_cnt <= BRK) begin
				next_s.low_cnt = s.low_cnt + 8'h01;
				if (s.low_cnt == BRK) begin
					next_s.lsr.brk = 1'b1;
					ev_err = 1'b1;
				end
			end
		end
		// Receiver: only the incoming line feeds the error flags
		if (tick) begin
			next_s.rx_prev = rxd;
			case (s.rxs)
				SPMH_RX_IDLE: begin
					if (s.rx_prev && !rxd && dsr && dcd) begin
						next_s.rxs = SPMH_RX_START;
						next_s.rx_sub = 4'h0;
					end
				end
				SPMH_RX_START: begin
					next_s.rx_sub = s.rx_sub + 4'h1;
					if (s.rx_sub == 4'h7) begin
						next_s.rx_sub = 4'h0;
						next_s.rx_bits = 4'h0;
						if (rxd) begin
							// Start bit vanished by mid-bit
							next_s.rxs = SPMH_RX_IDLE;
							next_s.lsr.frm = 1'b1;
							ev_err = 1'b1;
						end else begin
							next_s.rxs = SPMH_RX_DATA;
						end
					end
				end
				SPMH_RX_DATA: begin
					next_s.rx_sub = s.rx_sub + 4'h1;
					if (s.rx_sub == 4'hF) begin
						next_s.rx_sh = {rxd, s.rx_sh[8:1]};
						next_s.rx_bits = s.rx_bits + 4'h1;
						if (s.rx_bits == RLAST) begin
							next_s.rxs = SPMH_RX_STOP;
						end
					end
				end
				SPMH_RX_STOP: begin
					next_s.rx_sub = s.rx_sub + 4'h1;
					if (s.rx_sub == 4'hF) begin
						next_s.rxs = SPMH_RX_IDLE;
						if (!rxd) begin
							next_s.lsr.frm = 1'b1;
							ev_err = 1'b1;
						end
						if (PAR_EN && (rx_par != (^rx_byte ^ PAR_ODD))) begin
							next_s.lsr.par = 1'b1;
							ev_err = 1'b1;
						end
						// Single hold register; a full one loses the new byte
						if (next_s.lsr.rdy) begin
							next_s.lsr.ovr = 1'b1;
							ev_err = 1'b1;
						end else begin
							next_s.hold = rx_byte;
							next_s.lsr.rdy = 1'b1;
						end
					end
				end
				default: next_s.rxs = SPMH_RX_IDLE;
			endcase
		end
		if (ev_err) begin
			next_s.pend = 1'b1;
		end
		// DTR and RTS follow the operation unless forced active; DRS follows its force bit
		next_s.modem.dtr = next_s.mcr[`SPMH_MCR_DTR] ||
			next_s.op != SPMH_OP_IDLE;
		next_s.modem.rts = next_s.mcr[`SPMH_MCR_RTS] ||
			next_s.op == SPMH_OP_TX;
		next_s.modem.drs = next_s.mcr[`SPMH_MCR_DRS];
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.op <= SPMH_OP_IDLE;
			s.rxs <= SPMH_RX_IDLE;
			s.mcr <= `SPMH_MCR_RST;
			s.txd <= 1'b1;
			s.rx_prev <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops
	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign tx_ready = s.tx_ready;
	assign rx_valid = s.lsr.rdy;
	assign rx_data = s.hold;
	assign op_done = s.done;
	assign err_pending = s.pend;
	assign txd = s.txd;
	assign dtr = s.modem.dtr;
	assign rts = s.modem.rts;
	assign drs = s.modem.drs;

	////////////////////////////////////////////////////////////////////////
	// Checks on the handshake and error logic
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_tx_lines_up: assert property (
		s.op == SPMH_OP_TX |-> dtr && rts)
		else $error("DTR or RTS low during transmit");
	a_tx_handshake: assert property (
		tx_valid && tx_ready |-> $past(dsr) && $past(cts))
		else $error("Character taken without DSR and CTS");
	a_idle_lines_drop: assert property (
		s.op == SPMH_OP_IDLE |-> dtr == s.mcr[0] && rts == s.mcr[1])
		else $error("Modem line left active after operation");
	a_rx_rts_quiet: assert property (
		s.op == SPMH_OP_RX |-> dtr && rts == s.mcr[1])
		else $error("Receive lines wrong");
	a_drs_follows: assert property (
		reg_wr && reg_addr == `SPMH_MCR_OFS |=> drs == $past(reg_wdata[2]))
		else $error("Rate select did not follow force bit 2");
	a_tx_done_late: assert property (
		$rose(s.tx_fin) |-> !op_done [*8])
		else $error("Transmit completion before the last bit");
	a_frame_err: assert property (
		s.rxs == SPMH_RX_STOP && tick && s.rx_sub == 4'hF && !rxd
		|=> s.lsr.frm && err_pending)
		else $error("Missing stop bit not flagged");
	a_overrun: assert property (
		s.rxs == SPMH_RX_STOP && tick && s.rx_sub == 4'hF &&
		s.lsr.rdy && !rx_take |=> s.lsr.ovr && rx_data == $past(rx_data))
		else $error("Overrun not flagged or held byte lost");
	a_break_flag: assert property (
		tick && !rxd && s.low_cnt == BRK |=> s.lsr.brk)
		else $error("Break not flagged after a frame of space");
	a_err_source: assert property (
		ev_err |-> s.rxs != SPMH_RX_IDLE || !rxd)
		else $error("Line error raised without received data");
	a_pend_set: assert property (
		ev_err |=> err_pending)
		else $error("Pending error not raised");
	a_pend_clear: assert property (
		reg_rd && reg_addr == `SPMH_LSR_OFS && !ev_err |=> !err_pending)
		else $error("Status read did not clear pending error");

endmodule : spmh_top

// ==== tb/spmh_peer.sv ====
// Behavioural RS-232 peripheral facing the serial port
`timescale 1ns/100ps

module spmh_peer #(
	parameter int BIT = 80
) (
	input  wire logic clock,
	input  wire logic txd,
	output logic      rxd,
	output logic      dsr,
	output logic      cts,
	output logic      dcd
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// Bit time in cycles; the bench sets it to follow the chosen rate
	int         bit_t = BIT;

	////////////////////////////////////////////////////////////////////////
	// Line rests at mark; peer starts ready to talk and listen
	initial begin
		rxd = 1'b1;
		{dsr, cts, dcd} = 3'h7;
	end

	// Modem lines change just after an edge, like any synchronous input
	task set_lines(input logic [2:0] v);
		@(posedge clock);
		#1 {dsr, cts, dcd} = v;
	endtask : set_lines

	// Hold the receive line at one level for n bit times
	task put(input logic v, input int n);
		rxd = v;
		repeat (n * bit_t) @(posedge clock);
		#1;
	endtask : put

	// One frame at the shared rate: start, 8 data LSB first, stop, idle
	task frame(input logic [7:0] b, input logic stop);
		put(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			put(b[i], 1);
		end
		put(stop, 1);
		put(1'b1, 1);
	endtask : frame

	////////////////////////////////////////////////////////////////////////
	// Sample each sent data bit at its middle; a glitch would mis-sample data
	always begin
		@(negedge txd);
		repeat (bit_t / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_t) @(posedge clock);
			sh[i] = txd;
		end
		repeat (bit_t) @(posedge clock);
		got.push_back(sh);
	end

endmodule : spmh_peer

// ==== tb/serial_port_modem_handshake_tb_top.sv ====
// Self-checking bench for the serial port with modem handshake
`timescale 1ns/100ps
`include "spmh_regs.svh"

`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("unexpected at %0t: %s", $time, m); end end

module serial_port_modem_handshake_tb_top;
	import spmh_pkg::*;

	logic       clock, rstn, reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, rx_data, d;
	logic       tx_begin, tx_valid, tx_last, tx_ready, rx_begin, rx_end;
	logic       rx_take, rx_valid, op_done, err_pending, txd, rxd;
	logic       dtr, rts, drs, dsr, cts, dcd;
	logic [2:0] baud_sel;
	int         n_mismatch = 0;
	int         num_checks = 0;

	// Scaled clock rate: 19200 baud gives a tick every 5 cycles
	spmh_top #(.CLK_HZ(1600000)) DUT (
		.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.baud_sel(baud_sel), .tx_begin(tx_begin), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_begin(rx_begin), .rx_end(rx_end), .rx_take(rx_take),
		.rx_valid(rx_valid), .rx_data(rx_data), .op_done(op_done),
		.err_pending(err_pending), .txd(txd), .rxd(rxd), .dtr(dtr),
		.rts(rts), .drs(drs), .dsr(dsr), .cts(cts), .dcd(dcd));

	spmh_peer peer (
		.clock(clock), .txd(txd), .rxd(rxd), .dsr(dsr), .cts(cts),
		.dcd(dcd));

	////////////////////////////////////////////////////////////////////////
	// Free-running 125 MHz clock
	always #4 clock = ~clock;

	task tick;
		@(posedge clock);
		#1;
	endtask : tick

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task ran_out;
		n_mismatch++;
		$display("unexpected at %0t: wait ran out", $time);
		end_of_test;
	endtask : ran_out

	// Register strobes last one cycle; read answer comes the next cycle
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		tick;
		reg_wr = 1'b0;
		tick;
	endtask : wr

	task rd(input logic [7:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		tick;
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1, "no read answer")
		d = reg_rdata;
		tick;
	endtask : rd

	// Pulse one of the operation strobes for a single cycle
	task pulse(input int k);
		{tx_begin, rx_begin, rx_end, rx_take} = 4'h8 >> k;
		tick;
		{tx_begin, rx_begin, rx_end, rx_take} = 4'h0;
	endtask : pulse

	// Bounded wait for op_done, or rx_valid when rx is set
	task wait_hi(input bit rx, input int lim);
		int n;
		n = 0;
		while ((rx ? rx_valid : op_done) !== 1'b1) begin
			tick;
			n++;
			if (n > lim) ran_out;
		end
	endtask : wait_hi

	// Offer one character and hold it until the edge that takes it
	task send(input logic [7:0] b, input logic last);
		int n;
		bit ok;
		n = 0;
		tx_valid = 1'b1;
		tx_data = b;
		tx_last = last;
		// Ready is read while it stands, before the edge that samples it
		do begin
			ok = tx_ready === 1'b1;
			tick;
			n++;
			if (n > 3000) ran_out;
		end while (!ok);
		// Let one edge pass so a following offer never reuses this step
		tx_valid = 1'b0;
		tick;
	endtask : send

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(`SPMH_MCR_OFS);
		`CHK(d, `SPMH_MCR_RST, "force reg reset value")
		rd(8'h33);
		`CHK(d, 8'h00, "unmapped read")
		`CHK({dtr, rts, drs, txd}, 4'h1, "idle modem lines")
		$display("test reset done");
	endtask : t_reset

	// Two back-to-back characters under a given force setting
	task t_tx(input logic [7:0] f);
		wr(`SPMH_MCR_OFS, f);
		peer.got.delete();
		`CHK(drs, f[2], "rate select line")
		pulse(0);
		`CHK({dtr, rts}, 2'h3, "lines at transmit start")
		send(8'h3C, 1'b0);
		send(8'hC3, 1'b1);
		wait_hi(1'b0, 4000);
		`CHK(txd, 1'b1, "line idle at completion")
		`CHK(peer.got.size(), 2, "characters out at completion")
		`CHK(peer.got[0], 8'h3C, "first character")
		`CHK(peer.got[1], 8'hC3, "second character")
		`CHK({dtr, rts}, {f[0], f[1]}, "lines at transmit end")
		`CHK(err_pending, 1'b0, "transmit raised an error")
		wr(`SPMH_MCR_OFS, 8'h00);
		$display("test tx done");
	endtask : t_tx

	// Clear-to-send withheld at 9600 baud: 10 cycles a tick, 160 a bit
	task t_cts;
		baud_sel = 3'h4;
		peer.bit_t = 160;
		peer.got.delete();
		peer.set_lines(3'h5);
		pulse(0);
		repeat (40) begin
			`CHK(tx_ready, 1'b0, "ready without clear to send")
			tick;
		end
		peer.set_lines(3'h7);
		send(8'h5A, 1'b1);
		wait_hi(1'b0, 3000);
		`CHK(peer.got[0], 8'h5A, "held character")
		baud_sel = 3'h5;
		peer.bit_t = 80;
		$display("test cts done");
	endtask : t_cts

	// Receive, overrun, carrier loss and pending error clear
	task t_rx;
		pulse(1);
		`CHK({dtr, rts}, 2'h2, "lines at receive start")
		peer.frame(8'hA5, 1'b1);
		wait_hi(1'b1, 100);
		`CHK(rx_data, 8'hA5, "received character")
		pulse(3);
		`CHK(rx_valid, 1'b0, "hold not emptied")
		peer.frame(8'h11, 1'b1);
		peer.frame(8'h22, 1'b1);
		`CHK(rx_data, 8'h11, "held character replaced")
		`CHK(err_pending, 1'b1, "pending error")
		rd(`SPMH_LSR_OFS);
		`CHK(d, 8'h03, "overrun status")
		`CHK(err_pending, 1'b0, "pending error after read")
		rd(`SPMH_LSR_OFS);
		`CHK(d, 8'h01, "status after clear")
		pulse(3);
		peer.set_lines(3'h6);
		peer.frame(8'h77, 1'b1);
		`CHK(rx_valid, 1'b0, "accepted without carrier")
		peer.set_lines(3'h7);
		pulse(2);
		`CHK({op_done, dtr}, 2'h2, "receive end")
		$display("test rx done");
	endtask : t_rx

	// Bad stop bit, then a break longer than a whole frame
	task t_err;
		peer.frame(8'hFF, 1'b0);
		rd(`SPMH_LSR_OFS);
		`CHK(d & 8'h1E, 8'h08, "framing status")
		pulse(3);
		peer.put(1'b0, 20);
		peer.put(1'b1, 1);
		`CHK(err_pending, 1'b1, "pending after break")
		rd(`SPMH_LSR_OFS);
		`CHK(d & 8'h10, 8'h10, "break status")
		pulse(3);
		$display("test err done");
	endtask : t_err

	////////////////////////////////////////////////////////////////////////
	// Reset for 16 cycles, then run each scenario once, transmit twice under two force settings
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
		{tx_begin, tx_valid, tx_data, tx_last} = 11'h0;
		{rx_begin, rx_end, rx_take} = 3'h0;
		baud_sel = 3'h5;
		repeat (16) @(posedge clock);
		#1 rstn = 1'b1;
		t_reset;
		t_tx(8'h00);
		t_tx(8'h07);
		t_cts;
		t_rx;
		t_err;
		end_of_test;
	end

endmodule : serial_port_modem_handshake_tb_top
